/* File: hdl/b3cfg_regs.sv */
// register bank and set-point decode for the third buck regulator
// assumes a classic wishbone master on mclk; fuse and power-state pins are asynchronous
`timescale 1ns/1ns

module b3cfg_regs
  import b3cfg_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [B3CFG_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [B3CFG_DAT_W-1:0] wb_dat_i,
  output logic [B3CFG_DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  // fuse and power state pins
  input wire logic fuse_range_high,
  input wire logic standby_req,
  input wire logic sleep_req,
  // regulator controls
  output logic [6:0] buck3_active_code,
  output logic [11:0] buck3_vout_mv,
  output logic buck3_code_reserved,
  output logic buck3_enable,
  output logic buck3_pfm_force,
  output logic [3:0] buck3_switching_mode,
  output logic buck3_current_limit_low,
  output logic [1:0] buck3_frequency_sel,
  output logic [1:0] buck3_phase_clock_sel,
  output logic [1:0] buck3_slew_speed_sel
);

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [2:0] pin_meta_q;
  logic [2:0] pin_sync_q;

  always_ff @(posedge mclk) begin
    if (rst) begin
      pin_meta_q <= 3'h0;
      pin_sync_q <= 3'h0;
    end else begin
      pin_meta_q <= {sleep_req, standby_req, fuse_range_high};
      pin_sync_q <= pin_meta_q;
    end
  end

  logic range_high;
  logic standby_s;
  logic sleep_s;
  assign range_high = pin_sync_q[0];
  assign standby_s = pin_sync_q[1];
  assign sleep_s = pin_sync_q[2];

  // ****************************************
  // bus slave
  // ****************************************
  // answer one cycle after the request, then drop for a cycle
  logic ack_q;
  logic req;
  logic wr_en;
  logic [7:0] idx;

  assign req = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr_en = req && wb_we_i && wb_sel_i[0];
  assign idx = wb_adr_i[9:2];
  assign wb_ack_o = ack_q;

  always_ff @(posedge mclk) begin
    if (rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req;
    end
  end

  // ****************************************
  // registers
  // ****************************************
  logic [5:0] run_code_q;
  logic [5:0] stby_code_q;
  logic [5:0] sleep_code_q;
  logic [3:0] mode_q;
  logic sleep_state_q;
  logic [7:0] conf_q;

  always_ff @(posedge mclk) begin
    if (rst) begin
      run_code_q <= B3CFG_RST_SETPT;
      stby_code_q <= B3CFG_RST_SETPT;
      sleep_code_q <= B3CFG_RST_SETPT;
    end else if (wr_en) begin
      if (idx == B3CFG_IDX_RUN) begin
        run_code_q <= wb_dat_i[5:0];
      end
      if (idx == B3CFG_IDX_STBY) begin
        stby_code_q <= wb_dat_i[5:0];
      end
      if (idx == B3CFG_IDX_SLEEP) begin
        sleep_code_q <= wb_dat_i[5:0];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      mode_q <= B3CFG_RST_MODE;
      sleep_state_q <= 1'b0;
    end else if (wr_en && idx == B3CFG_IDX_MODE) begin
      mode_q <= wb_dat_i[3:0];
      sleep_state_q <= wb_dat_i[B3CFG_SLEEP_STATE_BIT];
    end
  end

  // the unused bit 1 is kept writable as the bank shows it
  always_ff @(posedge mclk) begin
    if (rst) begin
      conf_q <= B3CFG_RST_CONF;
    end else if (wr_en && idx == B3CFG_IDX_CONF) begin
      conf_q <= wb_dat_i[7:0];
    end
  end

  // ****************************************
  // read path
  // ****************************************
  logic [7:0] rd_mux;

  always_comb begin
    rd_mux = 8'h00;
    unique case (idx)
      B3CFG_IDX_RUN: rd_mux = {1'b0, range_high, run_code_q};
      B3CFG_IDX_STBY: rd_mux = {1'b0, range_high, stby_code_q};
      B3CFG_IDX_SLEEP: rd_mux = {1'b0, range_high, sleep_code_q};
      B3CFG_IDX_MODE: rd_mux = {2'b00, sleep_state_q, 1'b0, mode_q};
      B3CFG_IDX_CONF: rd_mux = conf_q;
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      wb_dat_o <= '0;
    end else if (req && !wb_we_i) begin
      wb_dat_o <= {24'h000000, rd_mux};
    end
  end

  // ****************************************
  // power state
  // ****************************************
  // sleep outranks standby when both pins are up
  b3cfg_pstate_type pstate_q;

  always_ff @(posedge mclk) begin
    if (rst) begin
      pstate_q <= B3CFG_RUN;
    end else if (sleep_s) begin
      pstate_q <= B3CFG_SLEEP;
    end else if (standby_s) begin
      pstate_q <= B3CFG_STANDBY;
    end else begin
      pstate_q <= B3CFG_RUN;
    end
  end

  // ****************************************
  // set-point decode
  // ****************************************
  logic [6:0] code_d;
  logic [11:0] mv_d;
  logic rsvd_d;

  // the spare fourth state code falls back to the run set point, so no latch is inferred
  always_comb begin
    code_d = {range_high, run_code_q};
    unique case (pstate_q)
      B3CFG_RUN: code_d = {range_high, run_code_q};
      B3CFG_STANDBY: code_d = {range_high, stby_code_q};
      B3CFG_SLEEP: code_d = {range_high, sleep_code_q};
    endcase
  end

  always_comb begin
    mv_d = 12'h000;
    rsvd_d = 1'b0;
    if (code_d[6]) begin
      rsvd_d = code_d > B3CFG_HIGH_LAST;
      if (!rsvd_d) begin
        mv_d = B3CFG_HIGH_BASE_MV
             + B3CFG_HIGH_STEP_MV * {5'h00, 7'(code_d - B3CFG_HIGH_FIRST)};
      end
    end else begin
      // low codes under nine not valid
      rsvd_d = code_d < B3CFG_LOW_FIRST;
      if (!rsvd_d) begin
        mv_d = B3CFG_LOW_BASE_MV
             + B3CFG_LOW_STEP_MV * {5'h00, 7'(code_d - B3CFG_LOW_FIRST)};
      end
    end
  end

  // ****************************************
  // regulator outputs
  // ****************************************
  always_ff @(posedge mclk) begin
    if (rst) begin
      buck3_active_code <= 7'h00;
      buck3_vout_mv <= 12'h000;
      buck3_code_reserved <= 1'b1;
    end else begin
      buck3_active_code <= code_d;
      buck3_vout_mv <= mv_d;
      buck3_code_reserved <= rsvd_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      buck3_enable <= 1'b0;
      buck3_pfm_force <= 1'b0;
    end else begin
      buck3_enable <= (pstate_q != B3CFG_SLEEP) || sleep_state_q;
      buck3_pfm_force <= (pstate_q == B3CFG_SLEEP) && sleep_state_q;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      buck3_switching_mode <= B3CFG_RST_MODE;
      buck3_current_limit_low <= 1'b0;
      buck3_frequency_sel <= 2'h0;
      buck3_phase_clock_sel <= 2'h0;
      buck3_slew_speed_sel <= 2'h0;
    end else begin
      buck3_switching_mode <= mode_q;
      buck3_current_limit_low <= conf_q[B3CFG_ILIM_BIT];
      buck3_frequency_sel <= conf_q[B3CFG_FREQ_LSB +: 2];
      buck3_phase_clock_sel <= conf_q[B3CFG_PHASE_LSB +: 2];
      buck3_slew_speed_sel <= conf_q[B3CFG_SLEW_LSB +: 2];
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  a_ack_one_shot: assert property (
    wb_ack_o |=> !wb_ack_o
  ) else $error("ack held longer than one cycle");

  a_ack_follows_req: assert property (
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o
  ) else $error("request not answered next cycle");

  a_run_write_lands: assert property (
    (wr_en && idx == B3CFG_IDX_RUN) |=> run_code_q == $past(wb_dat_i[5:0])
  ) else $error("run set point not stored");

  a_run_range_ro: assert property (
    (req && !wb_we_i && idx == B3CFG_IDX_RUN)
      |=> wb_dat_o[7:6] == {1'b0, $past(range_high)}
  ) else $error("run range bit readback wrong");

  a_stby_range_mirror: assert property (
    (req && !wb_we_i && idx == B3CFG_IDX_STBY)
      |=> wb_dat_o[6] == $past(range_high) && wb_dat_o[5:0] == $past(stby_code_q)
  ) else $error("standby readback wrong");

  a_sleep_range_copy: assert property (
    (req && !wb_we_i && idx == B3CFG_IDX_SLEEP)
      |=> wb_dat_o[6] == $past(range_high)
  ) else $error("sleep range bit readback wrong");

  a_sleep_hold: assert property (
    (!wr_en || idx != B3CFG_IDX_SLEEP) |=> $stable(sleep_code_q)
  ) else $error("sleep set point changed without write");

  a_stby_write_lands: assert property (
    (wr_en && idx == B3CFG_IDX_STBY) |=> stby_code_q == $past(wb_dat_i[5:0])
  ) else $error("standby set point not stored");

  a_mode_unused_zero: assert property (
    (req && !wb_we_i && idx == B3CFG_IDX_MODE)
      |=> wb_dat_o[7:6] == 2'b00 && !wb_dat_o[4]
  ) else $error("unused mode bits not zero");

  a_mode_write_out: assert property (
    (wr_en && idx == B3CFG_IDX_MODE) |=> ##1 buck3_switching_mode == $past(wb_dat_i[3:0], 2)
  ) else $error("mode selector not applied");

  a_sleep_off: assert property (
    (pstate_q == B3CFG_SLEEP && !sleep_state_q) |=> !buck3_enable && !buck3_pfm_force
  ) else $error("regulator not off in sleep");

  a_conf_fields: assert property (
    (wr_en && idx == B3CFG_IDX_CONF) |=> ##1 buck3_frequency_sel == $past(wb_dat_i[3:2], 2)
  ) else $error("frequency field not applied");

  a_ilim_follow: assert property (
    ##1 buck3_current_limit_low == $past(conf_q[B3CFG_ILIM_BIT])
  ) else $error("current limit select mismatch");

  a_phase_slew: assert property (
    ##1 {buck3_slew_speed_sel, buck3_phase_clock_sel} == $past(conf_q[7:4])
  ) else $error("phase or slew field mismatch");

  a_low_decode: assert property (
    (!code_d[6] && code_d >= B3CFG_LOW_FIRST)
      |=> buck3_vout_mv == 12'(16'h0190 + 16'h0019 * {9'h000, $past(code_d)})
  ) else $error("low range voltage decode wrong");

  a_high_reserved: assert property (
    (code_d > B3CFG_HIGH_LAST) |=> buck3_code_reserved && buck3_vout_mv == 12'h000
  ) else $error("reserved high code not flagged");

  c_run_write: cover property (wr_en && idx == B3CFG_IDX_RUN);
  c_sleep_pfm: cover property (buck3_pfm_force);
  c_reserved_code: cover property (buck3_code_reserved ##1 !buck3_code_reserved);
  c_unmapped_read: cover property (req && !wb_we_i && idx > B3CFG_IDX_CONF);

endmodule // b3cfg_regs

/* File: hdl/b3cfg_pkg.sv */
// constants for the third buck regulator configuration bank
// assumes a 32-bit classic wishbone bus, one register per aligned word
package b3cfg_pkg;

  // ****************************************
  // bus geometry
  // ****************************************
  localparam int B3CFG_ADR_W = 10;
  localparam int B3CFG_DAT_W = 32;

  // ****************************************
  // register indices, byte address is four times the index
  // ****************************************
  localparam logic [7:0] B3CFG_IDX_RUN = 8'h3c;
  localparam logic [7:0] B3CFG_IDX_STBY = 8'h3d;
  localparam logic [7:0] B3CFG_IDX_SLEEP = 8'h3e;
  localparam logic [7:0] B3CFG_IDX_MODE = 8'h3f;
  localparam logic [7:0] B3CFG_IDX_CONF = 8'h40;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [5:0] B3CFG_RST_SETPT = 6'h00;
  localparam logic [3:0] B3CFG_RST_MODE = 4'h8;
  localparam logic [7:0] B3CFG_RST_CONF = 8'h00;

  // ****************************************
  // field positions
  // ****************************************
  localparam int B3CFG_RANGE_BIT = 6;
  localparam int B3CFG_SLEEP_STATE_BIT = 5;
  localparam int B3CFG_ILIM_BIT = 0;
  localparam int B3CFG_FREQ_LSB = 2;
  localparam int B3CFG_PHASE_LSB = 4;
  localparam int B3CFG_SLEW_LSB = 6;

  // ****************************************
  // set-point decode, millivolts
  // ****************************************
  localparam logic [6:0] B3CFG_LOW_FIRST = 7'h09;
  localparam logic [6:0] B3CFG_HIGH_FIRST = 7'h40;
  localparam logic [6:0] B3CFG_HIGH_LAST = 7'h72;
  localparam logic [11:0] B3CFG_LOW_BASE_MV = 12'h271;
  localparam logic [11:0] B3CFG_LOW_STEP_MV = 12'h019;
  localparam logic [11:0] B3CFG_HIGH_BASE_MV = 12'h320;
  localparam logic [11:0] B3CFG_HIGH_STEP_MV = 12'h032;

  typedef enum logic [1:0] {
    B3CFG_RUN,
    B3CFG_STANDBY,
    B3CFG_SLEEP
  } b3cfg_pstate_type;

endpackage

/* File: sim/buck3_config_registers_tb.sv */
// self-checking bench for the buck3 configuration register bank
// assumes b3cfg_regs acks one cycle after taking a request; pins settle in 4 edges
`timescale 1ns/1ns

module buck3_config_registers_tb import b3cfg_pkg::*;;
  logic mclk = 1'b0;
  logic rst, cyc, stb, we, fuse, stby, slp;
  logic [9:0] adr;
  logic [3:0] sel;
  logic [31:0] dat_i, seed, v;
  logic [31:0] exp_q[$];
  logic [6:0] code;
  int fail_count, tests_run, cycles;
  // low codes 9 to 63 are what software uses; 8 only probes the reserved flag
  int tbl[6] = '{8, 9, 63, 64, 114, 115};
  wire [31:0] dat_o;
  wire ack, res, en, pulse_frequency_mode, ilim;
  wire [6:0] act;
  wire [11:0] mv_o;
  wire [3:0] mode;
  wire [1:0] freq, phase, slew;

  b3cfg_regs b3cfg_regs_inst (.mclk(mclk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_i), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .fuse_range_high(fuse), .standby_req(stby), .sleep_req(slp),
    .buck3_active_code(act), .buck3_vout_mv(mv_o), .buck3_code_reserved(res),
    .buck3_enable(en), .buck3_pfm_force(pulse_frequency_mode), .buck3_switching_mode(mode),
    .buck3_current_limit_low(ilim), .buck3_frequency_sel(freq),
    .buck3_phase_clock_sel(phase), .buck3_slew_speed_sel(slew));

  always #5 mclk = ~mclk;

  // ****************************************
  // shared tasks
  // ****************************************
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task complete_run;
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // classic single cycle, held until ack is sampled high
  task bus(input logic w, input logic [7:0] idx, input logic [3:0] s, input logic [31:0] d);
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    sel <= s;
    dat_i <= d;
    do @(posedge mclk); while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task wr(input logic [7:0] idx, input logic [31:0] d);
    bus(1'b1, idx, 4'h1, d);
  endtask

  task rd(input logic [7:0] idx, input logic [7:0] e);
    exp_q.push_back({24'h0, e});
    bus(1'b0, idx, 4'hf, $random(seed));
  endtask

  task pins(input logic f, input logic sb, input logic sl);
    @(posedge mclk);
    fuse <= f;
    stby <= sb;
    slp <= sl;
    repeat (6) @(posedge mclk);
  endtask

  // low range starts at 625 mV in 25 mV steps, high at 800 mV in 50 mV steps
  function automatic logic [11:0] volts(input logic [6:0] c);
    if (c < 7'h09 || c > 7'h72) return 12'h000;
    if (c < 7'h40) return 12'(625 + 25 * (int'(c) - 9));
    return 12'(800 + 50 * (int'(c) - 64));
  endfunction

  task outs(input logic [6:0] c, input logic e, input logic p);
    check("active code", {25'h0, act}, {25'h0, c});
    check("vout", {20'h0, mv_o}, {20'h0, volts(c)});
    check("reserved", {31'h0, res}, {31'h0, volts(c) == 12'h000});
    check("enable", {31'h0, en}, {31'h0, e});
    check("pfm", {31'h0, pulse_frequency_mode}, {31'h0, p});
  endtask

  // ****************************************
  // read monitor and watchdog
  // ****************************************
  always @(posedge mclk) begin
    if (ack === 1'b1 && we === 1'b0) begin
      if (exp_q.size() == 0) check("stray ack", 32'h1, 32'h0);
      else check("read data", dat_o, exp_q.pop_front());
    end
    cycles++;
    if (cycles > 20000) begin
      fail_count++;
      complete_run();
    end
  end

  initial begin
    seed = 32'h14b983ed;
    {rst, cyc, stb, we, fuse, stby, slp} = 7'b1000000;
    adr = 10'h000;
    sel = 4'h0;
    dat_i = 32'h0;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    rd(B3CFG_IDX_RUN, 8'h00);
    rd(B3CFG_IDX_STBY, 8'h00);
    rd(B3CFG_IDX_SLEEP, 8'h00);
    rd(B3CFG_IDX_MODE, 8'h08);
    rd(B3CFG_IDX_CONF, 8'h00);
    rd(8'h41, 8'h00);
    check("mode out", {28'h0, mode}, 32'h8);
    $display("test reset values done");
    wr(B3CFG_IDX_RUN, 32'hff);
    wr(B3CFG_IDX_STBY, 32'hff);
    wr(B3CFG_IDX_SLEEP, 32'hff);
    wr(B3CFG_IDX_MODE, 32'hff);
    wr(8'h41, 32'hff);
    bus(1'b1, B3CFG_IDX_RUN, 4'he, 32'h0);
    rd(B3CFG_IDX_RUN, 8'h3f);
    rd(B3CFG_IDX_STBY, 8'h3f);
    rd(B3CFG_IDX_SLEEP, 8'h3f);
    rd(B3CFG_IDX_MODE, 8'h2f);
    rd(8'h41, 8'h00);
    for (int i = 0; i < 8; i++) begin
      v = $random(seed);
      wr(B3CFG_IDX_CONF, v);
      wr(B3CFG_IDX_MODE, v);
      rd(B3CFG_IDX_CONF, v[7:0]);
      rd(B3CFG_IDX_MODE, {2'b00, v[5], 1'b0, v[3:0]});
      check("ilim", {31'h0, ilim}, {31'h0, v[0]});
      check("freq", {30'h0, freq}, {30'h0, v[3:2]});
      check("phase", {30'h0, phase}, {30'h0, v[5:4]});
      check("slew", {30'h0, slew}, {30'h0, v[7:6]});
      check("mode out", {28'h0, mode}, {28'h0, v[3:0]});
    end
    $display("test register access done");
    wr(B3CFG_IDX_MODE, 32'h08);
    for (int i = 0; i < 6; i++) begin
      code = 7'(tbl[i]);
      pins(code[6], 1'b0, 1'b0);
      wr(B3CFG_IDX_RUN, {26'h0, code[5:0]});
      repeat (4) @(posedge mclk);
      outs(code, 1'b1, 1'b0);
    end
    rd(B3CFG_IDX_STBY, 8'h7f);
    rd(B3CFG_IDX_SLEEP, 8'h7f);
    $display("test decode done");
    wr(B3CFG_IDX_STBY, 32'h14);
    wr(B3CFG_IDX_SLEEP, 32'h1e);
    pins(1'b1, 1'b1, 1'b0);
    outs(7'h54, 1'b1, 1'b0);
    pins(1'b1, 1'b1, 1'b1);
    outs(7'h5e, 1'b0, 1'b0);
    wr(B3CFG_IDX_MODE, 32'h28);
    repeat (4) @(posedge mclk);
    outs(7'h5e, 1'b1, 1'b1);
    $display("test power states done");
    @(posedge mclk);
    rst <= 1'b1;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    rd(B3CFG_IDX_MODE, 8'h08);
    rd(B3CFG_IDX_SLEEP, 8'h40);
    $display("test second reset done");
    repeat (2) @(posedge mclk);
    complete_run();
  end
endmodule // buck3_config_registers_tb
